/* File: rtl/mte_access.sv */
// Indirect host access to the address tables: shared entry words, static table
// sequencer, lookup table request port, destination decision and aging helper.
// Assumes the lookup engine, aging timer and forwarding path share clk_sys_i.
`timescale 1ns/100ps
module mte_access
   import mte_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   // Management register port
   input  wire logic [15:0] reg_addr_i,
   input  wire logic        reg_wr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_rd_i,
   output logic [31:0]      reg_rdata_o,
   // Lookup table engine
   output logic             lk_req_o,
   output logic [1:0]       lk_op_o,
   output mte_entry_t       lk_entry_o,
   input  wire logic        lk_done_i,
   input  wire logic        lk_found_i,
   input  wire mte_entry_t  lk_entry_i,
   // Destination lookup
   input  wire logic        da_req_i,
   input  wire logic [47:0] da_mac_i,
   input  wire logic [6:0]  da_fid_i,
   input  wire logic        dyn_hit_i,
   input  wire mte_entry_t  dyn_entry_i,
   output logic             da_valid_o,
   output mte_result_t      da_result_o,
   // Source learning check
   input  wire logic        sa_req_i,
   input  wire logic        sa_hit_i,
   input  wire mte_entry_t  sa_entry_i,
   output logic             sa_drop_o,
   // Aging helper for lookup table entries
   input  wire logic        age_req_i,
   input  wire logic        age_touch_i,
   input  wire mte_entry_t  age_entry_i,
   output logic             age_valid_o,
   output mte_entry_t       age_entry_o
);

   typedef enum {S_IDLE, S_ST_WRITE, S_ST_READ, S_ST_LOAD, S_LK_WAIT} mte_state_t;

   mte_state_t            state_r, state_nxt;
   mte_entry_t            entry_r, entry_nxt;
   logic [5:0]            st_idx_r, st_idx_nxt;
   logic                  st_op_r, st_op_nxt;
   logic                  st_sel_r, st_sel_nxt;
   logic                  st_go_r, st_go_nxt;
   logic [1:0]            lk_op_r, lk_op_nxt;
   logic                  lk_go_r, lk_go_nxt;
   logic                  lk_valid_r, lk_valid_nxt;
   logic                  lk_req_r, lk_req_nxt;
   logic [31:0]           rdata_r, rdata_nxt;

   logic                  mem_wr, mem_rd;
   mte_entry_t            mem_rd_data;
   mte_entry_t [MTE_ST_DEPTH-1:0] st_table;
   logic                  st_hit;
   logic [MTE_IDX_W-1:0]  st_hit_idx;

   logic                  da_valid_r, da_valid_nxt;
   mte_result_t           da_res_r, da_res_nxt;
   logic                  sa_drop_r, sa_drop_nxt;
   logic                  age_valid_r, age_valid_nxt;
   mte_entry_t            age_ent_r, age_ent_nxt;

   logic                  busy;
   logic                  dyn_live;

   assign busy = (state_r != S_IDLE);

   mte_static_mem u_mem (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .wr_en_i   (mem_wr),
      .wr_idx_i  (st_idx_r[MTE_IDX_W-1:0]),
      .wr_data_i (entry_r),
      .rd_en_i   (mem_rd),
      .rd_idx_i  (st_idx_r[MTE_IDX_W-1:0]),
      .rd_data_o (mem_rd_data),
      .table_o   (st_table)
   );

   mte_static_match u_match (
      .table_i (st_table),
      .mac_i   (da_mac_i),
      .fid_i   (da_fid_i),
      .hit_o   (st_hit),
      .idx_o   (st_hit_idx)
   );

   // Register access and table sequencing
   always_comb begin
      state_nxt    = state_r;
      entry_nxt    = entry_r;
      st_idx_nxt   = st_idx_r;
      st_op_nxt    = st_op_r;
      st_sel_nxt   = st_sel_r;
      st_go_nxt    = st_go_r;
      lk_op_nxt    = lk_op_r;
      lk_go_nxt    = lk_go_r;
      lk_valid_nxt = lk_valid_r;
      lk_req_nxt   = 1'b0;
      rdata_nxt    = rdata_r;
      mem_wr       = 1'b0;
      mem_rd       = 1'b0;

      if (reg_rd_i) begin
         case (reg_addr_i)
            MTE_ENTRY1_OFS: rdata_nxt = mte_word(entry_r, 2'h0);
            MTE_ENTRY2_OFS: rdata_nxt = mte_word(entry_r, 2'h1);
            MTE_ENTRY3_OFS: rdata_nxt = mte_word(entry_r, 2'h2);
            MTE_ENTRY4_OFS: rdata_nxt = mte_word(entry_r, 2'h3);
            MTE_ST_CTRL_OFS: begin
               rdata_nxt = 32'h0000_0000;
               rdata_nxt[ST_IDX_LSB +: 6] = st_idx_r;
               rdata_nxt[ST_OP_BIT]       = st_op_r;
               rdata_nxt[ST_SEL_BIT]      = st_sel_r;
               rdata_nxt[ST_GO_BIT]       = st_go_r;
            end
            MTE_LK_CTRL_OFS: begin
               rdata_nxt = 32'h0000_0000;
               rdata_nxt[LK_OP_LSB +: 2]  = lk_op_r;
               rdata_nxt[LK_GO_BIT]       = lk_go_r;
               rdata_nxt[LK_VALID_BIT]    = lk_valid_r;
            end
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end

      // Host writes are dropped while an operation runs, so the words stay coherent
      if (reg_wr_i && !busy) begin
         case (reg_addr_i)
            MTE_ENTRY1_OFS: entry_nxt = mte_put(entry_r, 2'h0, reg_wdata_i);
            MTE_ENTRY2_OFS: entry_nxt = mte_put(entry_r, 2'h1, reg_wdata_i);
            MTE_ENTRY3_OFS: entry_nxt = mte_put(entry_r, 2'h2, reg_wdata_i);
            MTE_ENTRY4_OFS: entry_nxt = mte_put(entry_r, 2'h3, reg_wdata_i);
            MTE_ST_CTRL_OFS: begin
               st_idx_nxt = reg_wdata_i[ST_IDX_LSB +: 6];
               st_op_nxt  = reg_wdata_i[ST_OP_BIT];
               st_sel_nxt = reg_wdata_i[ST_SEL_BIT];
               st_go_nxt  = reg_wdata_i[ST_GO_BIT];
               if (reg_wdata_i[ST_GO_BIT]) begin
                  if (reg_wdata_i[ST_SEL_BIT]) begin
                     // Multicast table is held elsewhere; finish at once
                     state_nxt = S_ST_LOAD;
                  end else if (reg_wdata_i[ST_OP_BIT]) begin
                     state_nxt = S_ST_READ;
                  end else begin
                     state_nxt = S_ST_WRITE;
                  end
               end
            end
            MTE_LK_CTRL_OFS: begin
               lk_op_nxt = reg_wdata_i[LK_OP_LSB +: 2];
               lk_go_nxt = reg_wdata_i[LK_GO_BIT];
               if (reg_wdata_i[LK_GO_BIT]) begin
                  lk_valid_nxt = 1'b0;
                  lk_req_nxt   = 1'b1;
                  state_nxt    = S_LK_WAIT;
               end
            end
            default: ;
         endcase
      end

      case (state_r)
         S_IDLE: ;
         S_ST_WRITE: begin
            mem_wr    = 1'b1;
            st_go_nxt = 1'b0;
            state_nxt = S_IDLE;
         end
         S_ST_READ: begin
            mem_rd    = 1'b1;
            state_nxt = S_ST_LOAD;
         end
         S_ST_LOAD: begin
            if (!st_sel_r) begin
               entry_nxt = mem_rd_data;
            end
            st_go_nxt = 1'b0;
            state_nxt = S_IDLE;
         end
         S_LK_WAIT: begin
            if (lk_done_i) begin
               if (lk_op_r != LK_OP_WRITE) begin
                  entry_nxt = lk_found_i ? lk_entry_i : '0;
               end
               lk_valid_nxt = lk_found_i;
               lk_go_nxt    = 1'b0;
               state_nxt    = S_IDLE;
            end
         end
         default: state_nxt = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_r    <= S_IDLE;
         entry_r    <= '0;
         st_idx_r   <= 6'h00;
         st_op_r    <= 1'b0;
         st_sel_r   <= 1'b0;
         st_go_r    <= 1'b0;
         lk_op_r    <= 2'h0;
         lk_go_r    <= 1'b0;
         lk_valid_r <= 1'b0;
         lk_req_r   <= 1'b0;
         rdata_r    <= 32'h0000_0000;
      end else begin
         state_r    <= state_nxt;
         entry_r    <= entry_nxt;
         st_idx_r   <= st_idx_nxt;
         st_op_r    <= st_op_nxt;
         st_sel_r   <= st_sel_nxt;
         st_go_r    <= st_go_nxt;
         lk_op_r    <= lk_op_nxt;
         lk_go_r    <= lk_go_nxt;
         lk_valid_r <= lk_valid_nxt;
         lk_req_r   <= lk_req_nxt;
         rdata_r    <= rdata_nxt;
      end
   end

   // A dynamic entry whose age ran out counts as absent
   assign dyn_live = dyn_hit_i && (dyn_entry_i.flag || dyn_entry_i.prio_age != MTE_AGE_EXPIRED);

   // Forwarding decisions
   always_comb begin
      da_valid_nxt  = da_req_i;
      da_res_nxt    = '0;
      sa_drop_nxt   = sa_req_i && sa_hit_i && sa_entry_i.src_drop;
      if (da_req_i) begin
         // Static table first, then the one lookup table entry, static or dynamic with age left
         if (st_hit) begin
            da_res_nxt.hit       = 1'b1;
            da_res_nxt.is_static = 1'b1;
            da_res_nxt.dst_drop  = st_table[st_hit_idx].dst_drop;
            da_res_nxt.bypass    = st_table[st_hit_idx].bypass;
            da_res_nxt.prio      = st_table[st_hit_idx].prio_age;
            da_res_nxt.fwd       = st_table[st_hit_idx].fwd;
         end else if (dyn_live) begin
            da_res_nxt.hit       = 1'b1;
            da_res_nxt.is_static = dyn_entry_i.flag;
            da_res_nxt.dst_drop  = dyn_entry_i.dst_drop;
            da_res_nxt.bypass    = dyn_entry_i.bypass;
            da_res_nxt.prio      = dyn_entry_i.flag ? dyn_entry_i.prio_age : 3'h0;
            da_res_nxt.fwd       = dyn_entry_i.fwd;
         end
      end
   end

   // Aging and refresh of lookup table entries only
   always_comb begin
      age_valid_nxt = age_req_i;
      age_ent_nxt   = age_entry_i;
      if (age_req_i && !age_entry_i.flag) begin
         if (age_touch_i) begin
            age_ent_nxt.prio_age = MTE_AGE_DEFAULT;
         end else if (age_entry_i.prio_age != MTE_AGE_EXPIRED) begin
            age_ent_nxt.prio_age = age_entry_i.prio_age - 3'h1;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         da_valid_r  <= 1'b0;
         da_res_r    <= '0;
         sa_drop_r   <= 1'b0;
         age_valid_r <= 1'b0;
         age_ent_r   <= '0;
      end else begin
         da_valid_r  <= da_valid_nxt;
         da_res_r    <= da_res_nxt;
         sa_drop_r   <= sa_drop_nxt;
         age_valid_r <= age_valid_nxt;
         age_ent_r   <= age_ent_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;
   assign lk_req_o    = lk_req_r;
   assign lk_op_o     = lk_op_r;
   assign lk_entry_o  = entry_r;
   assign da_valid_o  = da_valid_r;
   assign da_result_o = da_res_r;
   assign sa_drop_o   = sa_drop_r;
   assign age_valid_o = age_valid_r;
   assign age_entry_o = age_ent_r;

endmodule : mte_access

/* File: rtl/mte_pkg.sv */
// Shared constants, carriers and word packing for the address table access block.
// Assumes a byte-addressed management register port on the switch core clock.
package mte_pkg;

   // Register byte offsets
   localparam logic [15:0] MTE_LK_CTRL_OFS = 16'h0418;
   localparam logic [15:0] MTE_ST_CTRL_OFS = 16'h041C;
   localparam logic [15:0] MTE_ENTRY1_OFS  = 16'h0420;
   localparam logic [15:0] MTE_ENTRY2_OFS  = 16'h0424;
   localparam logic [15:0] MTE_ENTRY3_OFS  = 16'h0428;
   localparam logic [15:0] MTE_ENTRY4_OFS  = 16'h042C;

   // Entry word field positions
   localparam int W1_FLAG_BIT   = 31;
   localparam int W1_SRC_BIT    = 30;
   localparam int W1_DST_BIT    = 29;
   localparam int W1_PRIO_LSB   = 26;
   localparam int W1_SPAN_LSB   = 0;
   localparam int W2_BYPASS_BIT = 31;
   localparam int W2_FWD_LSB    = 0;
   localparam int W3_FID_LSB    = 16;
   localparam int W3_MACHI_LSB  = 0;

   // Static table control register fields
   localparam int ST_IDX_LSB = 0;
   localparam int ST_OP_BIT  = 6;
   localparam int ST_SEL_BIT = 7;
   localparam int ST_GO_BIT  = 8;

   // Lookup table access control register fields
   localparam int LK_OP_LSB    = 0;
   localparam int LK_GO_BIT    = 2;
   localparam int LK_VALID_BIT = 3;

   localparam int MTE_ST_DEPTH = 16;
   localparam int MTE_IDX_W    = 4;

   localparam logic [1:0] LK_OP_WRITE  = 2'h1;
   localparam logic [1:0] LK_OP_READ   = 2'h2;
   localparam logic [1:0] LK_OP_SEARCH = 2'h3;

   // Aging_counter reloaded on learn or access; value is a plain default
   localparam logic [2:0] MTE_AGE_DEFAULT = 3'h7;
   localparam logic [2:0] MTE_AGE_EXPIRED = 3'h0;

   // Only writable fields are stored, so reserved bits can never hold a one
   typedef struct packed {
      logic        flag;      // static (lookup table) or valid (static table)
      logic        src_drop;
      logic        dst_drop;
      logic [2:0]  prio_age;
      logic [2:0]  span_grp;
      logic        bypass;
      logic [6:0]  fwd;
      logic [6:0]  vlan_filter_id;
      logic [47:0] mac;
   } mte_entry_t;

   typedef struct packed {
      logic       hit;
      logic       is_static;
      logic       dst_drop;
      logic       bypass;
      logic [2:0] prio;
      logic [6:0] fwd;
   } mte_result_t;

   function automatic logic [31:0] mte_word(input mte_entry_t e, input logic [1:0] sel);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (sel)
         2'h0: begin
            w[W1_FLAG_BIT]              = e.flag;
            w[W1_SRC_BIT]               = e.src_drop;
            w[W1_DST_BIT]               = e.dst_drop;
            w[W1_PRIO_LSB +: 3]         = e.prio_age;
            w[W1_SPAN_LSB +: 3]         = e.span_grp;
         end
         2'h1: begin
            w[W2_BYPASS_BIT]            = e.bypass;
            w[W2_FWD_LSB +: 7]          = e.fwd;
         end
         2'h2: begin
            w[W3_FID_LSB +: 7]          = e.vlan_filter_id;
            w[W3_MACHI_LSB +: 16]       = e.mac[47:32];
         end
         default: w = e.mac[31:0];
      endcase
      return w;
   endfunction : mte_word

   function automatic mte_entry_t mte_put(input mte_entry_t e, input logic [1:0] sel,
                                          input logic [31:0] w);
      mte_entry_t n;
      n = e;
      case (sel)
         2'h0: begin
            n.flag     = w[W1_FLAG_BIT];
            n.src_drop = w[W1_SRC_BIT];
            n.dst_drop = w[W1_DST_BIT];
            n.prio_age = w[W1_PRIO_LSB +: 3];
            n.span_grp = w[W1_SPAN_LSB +: 3];
         end
         2'h1: begin
            n.bypass   = w[W2_BYPASS_BIT];
            n.fwd      = w[W2_FWD_LSB +: 7];
         end
         2'h2: begin
            n.vlan_filter_id        = w[W3_FID_LSB +: 7];
            n.mac[47:32] = w[W3_MACHI_LSB +: 16];
         end
         default: n.mac[31:0] = w;
      endcase
      return n;
   endfunction : mte_put

endpackage : mte_pkg

/* File: rtl/mte_static_match.sv */
// Parallel destination match over every static table entry.
// Assumes the table input is stable flops; result is combinational.
`timescale 1ns/100ps
module mte_static_match
   import mte_pkg::*;
(
   input  wire mte_entry_t [MTE_ST_DEPTH-1:0] table_i,
   input  wire logic [47:0]                   mac_i,
   input  wire logic [6:0]                    fid_i,
   output logic                               hit_o,
   output logic [MTE_IDX_W-1:0]               idx_o
);

   logic [MTE_ST_DEPTH-1:0] match;

   genvar g;
   generate
      for (g = 0; g < MTE_ST_DEPTH; g++) begin : g_cmp
         // Invalid entries are left out of lookups
         assign match[g] = table_i[g].flag && (table_i[g].mac == mac_i)
                           && (table_i[g].vlan_filter_id == fid_i);
      end
   endgenerate

   // Lowest index wins when several entries match
   always_comb begin
      hit_o = 1'b0;
      idx_o = '0;
      for (int i = MTE_ST_DEPTH - 1; i >= 0; i--) begin
         if (match[i]) begin
            hit_o = 1'b1;
            idx_o = MTE_IDX_W'(i);
         end
      end
   end

endmodule : mte_static_match

/* File: rtl/mte_static_mem.sv */
// Sixteen-entry static address store with a registered host read port.
// Assumes one writer (the access sequencer); all entries are also exposed for matching.
`timescale 1ns/100ps
module mte_static_mem
   import mte_pkg::*;
(
   input  wire logic                             clk_sys_i,
   input  wire logic                             reset_i,
   input  wire logic                             wr_en_i,
   input  wire logic [MTE_IDX_W-1:0]             wr_idx_i,
   input  wire mte_entry_t                       wr_data_i,
   input  wire logic                             rd_en_i,
   input  wire logic [MTE_IDX_W-1:0]             rd_idx_i,
   output mte_entry_t                            rd_data_o,
   output mte_entry_t [MTE_ST_DEPTH-1:0]         table_o
);

   mte_entry_t [MTE_ST_DEPTH-1:0] mem_r, mem_nxt;
   mte_entry_t                    rd_r, rd_nxt;

   // Nothing but the host write port touches the store, so aging never reaches it
   always_comb begin
      mem_nxt = mem_r;
      rd_nxt  = rd_r;
      if (wr_en_i) begin
         mem_nxt[wr_idx_i] = wr_data_i;
      end
      if (rd_en_i) begin
         rd_nxt = mem_r[rd_idx_i];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         mem_r <= '0;
         rd_r  <= '0;
      end else begin
         mem_r <= mem_nxt;
         rd_r  <= rd_nxt;
      end
   end

   assign rd_data_o = rd_r;
   assign table_o   = mem_r;

endmodule : mte_static_mem

/* File: verif/mte_access_monitor.sv */
// Assertion checker for the address table access block.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/100ps
module mte_access_monitor
   import mte_pkg::*;
(
   input wire logic        clk_sys_i,
   input wire logic        reset_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic        reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic [1:0]  lk_op_o,
   input wire logic        lk_done_i,
   input wire logic        lk_found_i,
   input wire logic        da_req_i,
   input wire logic        da_valid_o,
   input wire logic        sa_req_i,
   input wire logic        sa_hit_i,
   input wire mte_entry_t  sa_entry_i,
   input wire logic        sa_drop_o,
   input wire logic        age_req_i,
   input wire logic        age_touch_i,
   input wire mte_entry_t  age_entry_i,
   input wire mte_entry_t  age_entry_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   sequence s_rd(logic [15:0] a);
      reg_rd_i && reg_addr_i == a;
   endsequence
   sequence s_miss;
      lk_done_i && !lk_found_i && lk_op_o == LK_OP_READ;
   endsequence
   a_unmapped_zero: assert property (reg_rd_i && reg_addr_i[15:8] != 8'h04
      |=> reg_rdata_o == 32'h0) else $error("unmapped read not zero");
   a_word1_resv: assert property (s_rd(MTE_ENTRY1_OFS)
      |=> reg_rdata_o[25:3] == 23'h0) else $error("word1 reserved bits set");
   a_word2_resv: assert property (s_rd(MTE_ENTRY2_OFS)
      |=> reg_rdata_o[30:7] == 24'h0) else $error("word2 reserved bits set");
   a_miss_zeros: assert property (s_miss ##[3:40] s_rd(MTE_ENTRY4_OFS)
      |=> reg_rdata_o == 32'h0) else $error("lookup miss left data");
   a_da_answer: assert property (da_req_i |=> da_valid_o)
      else $error("no lookup answer");
   a_src_drop: assert property (sa_req_i
      |=> sa_drop_o == $past(sa_hit_i && sa_entry_i.src_drop)) else $error("source drop wrong");
   a_age_static: assert property (age_req_i && age_entry_i.flag
      |=> age_entry_o.flag && age_entry_o.prio_age == $past(age_entry_i.prio_age))
      else $error("static entry aged");
   a_age_reload: assert property (age_req_i && age_touch_i && !age_entry_i.flag
      |=> age_entry_o.prio_age == MTE_AGE_DEFAULT) else $error("age not reloaded");
   a_age_decrement: assert property (age_req_i && !age_touch_i && !age_entry_i.flag
      |=> age_entry_o.prio_age == ($past(age_entry_i.prio_age) == 3'h0 ? 3'h0
      : $past(age_entry_i.prio_age) - 3'h1)) else $error("age not decremented");
endmodule : mte_access_monitor
bind mte_access mte_access_monitor u_mon (.clk_sys_i, .reset_i, .reg_addr_i, .reg_rd_i,
   .reg_rdata_o, .lk_op_o, .lk_done_i, .lk_found_i, .da_req_i, .da_valid_o, .sa_req_i,
   .sa_hit_i, .sa_entry_i, .sa_drop_o, .age_req_i, .age_touch_i, .age_entry_i, .age_entry_o);

/* File: verif/mte_lk_model.sv */
// Behavioural lookup engine on the far side of the lookup request port.
// Assumes one request at a time; delay and outcome are set by the bench.
`timescale 1ns/100ps
module mte_lk_model
   import mte_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic       reset_i,
   input  wire logic       req_i,
   input  wire logic [3:0] dly_i,
   input  wire logic       found_i,
   input  wire mte_entry_t entry_i,
   output logic            done_o,
   output logic            found_o,
   output mte_entry_t      entry_o
);
   logic       busy_r;
   logic [3:0] cnt_r;
   always_ff @(posedge clk_sys_i) begin
      done_o <= 1'b0;
      // Result lines churn outside the answer cycle, so stale data is never trusted
      found_o <= ~found_o;
      entry_o <= ~entry_o;
      if (reset_i) begin
         busy_r  <= 1'b0;
         cnt_r   <= 4'h0;
         found_o <= 1'b0;
         entry_o <= '0;
      end else if (req_i) begin
         busy_r <= 1'b1;
         cnt_r  <= dly_i;
      end else if (busy_r && cnt_r == 4'h0) begin
         busy_r  <= 1'b0;
         done_o  <= 1'b1;
         found_o <= found_i;
         entry_o <= entry_i;
      end else if (busy_r) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end
endmodule : mte_lk_model

/* File: verif/tb_mac_table_entry_access.sv */
// Self-checking bench for the address table access block.
// Assumes mte_lk_model answers the lookup port; host cycles come from tasks here.
`timescale 1ns/100ps
module tb_mac_table_entry_access;
   import mte_pkg::*;
   logic        clk_sys_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic [15:0] reg_addr_i = 16'h0;
   logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, rng = 32'h98C8;
   logic        lk_req_o, lk_done_i, lk_found_i, da_valid_o, sa_drop_o, age_valid_o;
   logic [1:0]  lk_op_o;
   mte_entry_t  lk_entry_o, lk_entry_i, age_entry_o, lk_ent = '0;
   logic        da_req_i = 1'b0, dyn_hit_i = 1'b0, sa_req_i = 1'b0, sa_hit_i = 1'b0;
   logic        age_req_i = 1'b0, age_touch_i = 1'b0, lk_fnd = 1'b0;
   logic [47:0] da_mac_i = 48'h0;
   logic [6:0]  da_fid_i = 7'h0;
   mte_entry_t  dyn_entry_i = '0, sa_entry_i = '0, age_entry_i = '0;
   mte_result_t da_result_o;
   logic [3:0]  lk_dly = 4'h0;
   int          n_errors = 0, cmp_count = 0;
   logic [31:0] sm [16][4];
   localparam logic [31:0] MSK [4] = '{32'hFC00_0007, 32'h8000_007F, 32'h007F_FFFF,
                                       32'hFFFF_FFFF};
   always #2 clk_sys_i = ~clk_sys_i;
   mte_access DUT (.clk_sys_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
      .reg_rdata_o, .lk_req_o, .lk_op_o, .lk_entry_o, .lk_done_i, .lk_found_i, .lk_entry_i,
      .da_req_i, .da_mac_i, .da_fid_i, .dyn_hit_i, .dyn_entry_i, .da_valid_o, .da_result_o,
      .sa_req_i, .sa_hit_i, .sa_entry_i, .sa_drop_o, .age_req_i, .age_touch_i, .age_entry_i,
      .age_valid_o, .age_entry_o);
   mte_lk_model LKM (.clk_sys_i, .reset_i, .req_i(lk_req_o), .dly_i(lk_dly), .found_i(lk_fnd),
      .entry_i(lk_ent), .done_o(lk_done_i), .found_o(lk_found_i), .entry_o(lk_entry_i));
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : rnd
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
      end
   endtask : chk
   task automatic tick();
      @(posedge clk_sys_i);
      #1;
   endtask : tick
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      tick();
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      tick();
      reg_wr_i = 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      tick();
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      tick();
      reg_rd_i = 1'b0;
      d = reg_rdata_o;
   endtask : rd
   task automatic wait_go(input logic [15:0] a, input int b);
      logic [31:0] d = 32'hFFFF_FFFF;
      for (int i = 0; i < 20 && d[b] !== 1'b0; i++) rd(a, d);
      chk(32'(d[b]), 32'h0, "go_done");
   endtask : wait_go
   task automatic check_words(input logic [31:0] exp [4]);
      logic [31:0] d;
      for (int k = 0; k < 4; k++) begin
         rd(MTE_ENTRY1_OFS + 16'(4 * k), d);
         chk(d, exp[k], "entry word");
      end
   endtask : check_words
   task automatic st_op(input int i, input logic rd_op);
      wr(MTE_ST_CTRL_OFS, 32'(i) | 32'(rd_op) << ST_OP_BIT | 32'h1 << ST_GO_BIT);
      wait_go(MTE_ST_CTRL_OFS, ST_GO_BIT);
   endtask : st_op
   task automatic st_write(input int i);
      for (int k = 0; k < 4; k++) wr(MTE_ENTRY1_OFS + 16'(4 * k), sm[i][k]);
      st_op(i, 1'b0);
   endtask : st_write
   task automatic tally_and_finish();
      $display("compares %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   initial begin
      #200000;
      n_errors++;
      tally_and_finish();
   end
   initial begin
      logic [31:0] d;
      logic [31:0] z [4];
      logic [31:0] w [4];
      logic [95:0] rv;
      mte_entry_t  e;
      logic [47:0] m;
      logic [2:0]  ag;
      z = '{default: 32'h0};
      repeat (16) @(posedge clk_sys_i);
      #1 reset_i = 1'b0;
      check_words(z);
      rd(16'h0500, d);
      chk(d, 32'h0, "unmapped");
      for (int k = 0; k < 4; k++) wr(MTE_ENTRY1_OFS + 16'(4 * k), 32'hFFFF_FFFF);
      check_words(MSK);
      $display("test reset and reserved bits done");
      for (int i = 0; i < 16; i++) begin
         for (int k = 0; k < 4; k++) sm[i][k] = rnd() & MSK[k];
         st_write(i);
      end
      for (int i = 15; i >= 0; i--) begin
         st_op(i, 1'b1);
         check_words(sm[i]);
      end
      $display("test static table fill done");
      sm[15][0][31] = 1'b1;
      st_write(15);
      m = {sm[15][2][15:0], sm[15][3]};
      for (int c = 0; c < 4; c++) begin
         if (c == 1) begin
            sm[15][0][31] = 1'b0;
            st_write(15);
         end
         rv = {rnd(), rnd(), rnd()};
         e = rv[71:0];
         e.flag = (c == 3);
         e.prio_age = (c >= 2) ? 3'h0 : 3'h5;
         tick();
         {da_req_i, da_mac_i, da_fid_i, dyn_hit_i, dyn_entry_i} = {1'b1, m, sm[15][2][22:16], 1'b1, e};
         tick();
         da_req_i = 1'b0;
         chk(32'(da_result_o.hit), 32'(c != 2), "da hit");
         chk(32'(da_valid_o), 32'h1, "da valid");
         if (c != 2) begin
            chk(32'(da_result_o.is_static), 32'(c != 1), "da static");
            chk(32'(da_result_o.fwd), 32'(c == 0 ? sm[15][1][6:0] : e.fwd), "da fwd");
            chk(32'(da_result_o.dst_drop), 32'(c == 0 ? sm[15][0][29] : e.dst_drop), "drop");
            chk(32'(da_result_o.prio), 32'(c == 0 ? sm[15][0][28:26] : 3'h0), "prio");
            chk(32'(da_result_o.bypass), 32'(c == 0 ? sm[15][1][31] : e.bypass), "byp");
         end
      end
      $display("test destination lookup done");
      for (int c = 0; c < 2; c++) begin
         rv = {rnd(), rnd(), rnd()};
         lk_ent = rv[71:0];
         lk_fnd = (c == 0);
         lk_dly = (c == 0) ? 4'h5 : 4'h0;
         wr(MTE_LK_CTRL_OFS, 32'h6);
         wait_go(MTE_LK_CTRL_OFS, LK_GO_BIT);
         rd(MTE_LK_CTRL_OFS, d);
         chk(32'(d[LK_VALID_BIT]), 32'(lk_fnd), "lookup valid");
         chk(32'(lk_op_o), 32'(LK_OP_READ), "lookup op");
         e = lk_ent;
         w = '{{e.flag, e.src_drop, e.dst_drop, e.prio_age, 23'h0, e.span_grp},
               {e.bypass, 24'h0, e.fwd}, {9'h0, e.vlan_filter_id, e.mac[47:32]}, e.mac[31:0]};
         check_words(lk_fnd ? w : z);
      end
      $display("test lookup read done");
      for (int i = 0; i < 12; i++) begin
         rv = {rnd(), rnd(), rnd()};
         e = rv[71:0];
         ag = e.flag ? e.prio_age : rv[95] ? MTE_AGE_DEFAULT
            : (e.prio_age == 3'h0 ? 3'h0 : e.prio_age - 3'h1);
         tick();
         {age_req_i, age_touch_i, age_entry_i} = {1'b1, rv[95], e};
         tick();
         age_req_i = 1'b0;
         chk(32'(age_valid_o), 32'h1, "age valid");
         chk(32'(age_entry_o.prio_age), 32'(ag), "aging_counter");
      end
      for (int i = 0; i < 4; i++) begin
         rv = {rnd(), rnd(), rnd()};
         tick();
         {sa_req_i, sa_hit_i, sa_entry_i} = {1'b1, rv[95], rv[71:0]};
         tick();
         sa_req_i = 1'b0;
         chk(32'(sa_drop_o), 32'(rv[95] & sa_entry_i.src_drop), "source drop");
      end
      st_op(0, 1'b1);
      check_words(sm[0]);
      $display("test aging and source check done");
      tally_and_finish();
   end
endmodule : tb_mac_table_entry_access
